// ==== design/dcp_top.sv ====
// Notes on behaviour
// - Command 04H loads next byte into control
// - Under read protect halt bit only sets
// - Command 05H returns the control register byte
// - Command 06H takes counter high then low
// - Counter write dropped outside debug or protected
// - Command 07H returns counter high then low
// - Counter read gives FFFFH when blocked
// - Size zero means 256, else literal
// - Register writes dropped outside debug mode
// - Protected register writes reach flash control only
// - 09H reads registers, FFH when blocked
`timescale 1ns/1ps
`include "dcp_defines.svh"

module dcp_top (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        read_protect,
  input  wire logic [15:0] program_counter,
  input  wire logic [7:0]  rf_rdata,
  input  wire logic        tx_ready,
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  output logic [7:0]       debug_control_reg,
  output logic             debug_halt_mode_bit,
  output logic             pc_load,
  output logic [15:0]      pc_load_value,
  output logic             rf_wr,
  output logic             rf_rd,
  output logic [11:0]      rf_addr,
  output logic [7:0]       rf_wdata
);

  dcp_pkg::dcp_state_type state_ff;
  dcp_pkg::dcp_state_type ret_state_ff;
  logic [7:0]  ctl_ff;
  logic [7:0]  pc_hi_ff;
  logic        pc_load_ff;
  logic [15:0] pc_val_ff;
  logic        rf_wr_ff;
  logic        rf_rd_ff;
  logic [11:0] addr_ff;
  logic [11:0] rf_addr_ff;
  logic [7:0]  wdata_ff;
  logic [8:0]  cnt_ff;
  logic        load_ff;
  logic        two_ff;
  logic [7:0]  first_ff;
  logic [7:0]  second_ff;
  logic        debug_on;
  logic        access_ok;
  logic        flash_hit;
  logic [8:0]  size_cnt;

  dcp_reply_if rp_if ();

  assign debug_on  = ctl_ff[`DCP_HALT_BIT];
  // Debug mode with protection off opens the counter and register reads
  assign access_ok = debug_on && !read_protect;
  assign flash_hit = (addr_ff >= `DCP_FLASH_LO) && (addr_ff <= `DCP_FLASH_HI);
  assign size_cnt  = (rx_data == 8'h00) ? `DCP_SIZE_ZERO_CNT : {1'b0, rx_data};

  assign rp_if.load   = load_ff;
  assign rp_if.two    = two_ff;
  assign rp_if.first  = first_ff;
  assign rp_if.second = second_ff;

  assign debug_control_reg   = ctl_ff;
  assign debug_halt_mode_bit = ctl_ff[`DCP_HALT_BIT];
  assign pc_load             = pc_load_ff;
  assign pc_load_value       = pc_val_ff;
  assign rf_wr               = rf_wr_ff;
  assign rf_rd               = rf_rd_ff;
  assign rf_addr             = rf_addr_ff;
  assign rf_wdata            = wdata_ff;

  // Command sequencer; bytes arriving while a reply drains are not taken
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_ff     <= dcp_pkg::ST_IDLE;
      ret_state_ff <= dcp_pkg::ST_IDLE;
      cnt_ff       <= 9'h000;
      addr_ff      <= 12'h000;
      pc_hi_ff     <= 8'h00;
    end
    else
    begin
      unique case (state_ff)
        dcp_pkg::ST_IDLE:
        begin
          if (rx_valid)
          begin
            ret_state_ff <= dcp_pkg::ST_IDLE;
            if (rx_data == `DCP_CMD_WR_CTL)
              state_ff <= dcp_pkg::ST_WCTL;
            else if (rx_data == `DCP_CMD_RD_CTL)
              state_ff <= dcp_pkg::ST_TXWAIT;
            else if (rx_data == `DCP_CMD_WR_PC)
              state_ff <= dcp_pkg::ST_PCH;
            else if (rx_data == `DCP_CMD_RD_PC)
              state_ff <= dcp_pkg::ST_TXWAIT;
            else if (rx_data == `DCP_CMD_WR_REG)
              state_ff <= dcp_pkg::ST_WAH;
            else if (rx_data == `DCP_CMD_RD_REG)
              state_ff <= dcp_pkg::ST_RAH;
            else
              state_ff <= dcp_pkg::ST_IDLE;
          end
        end
        dcp_pkg::ST_WCTL:
          if (rx_valid)
            state_ff <= dcp_pkg::ST_IDLE;
        dcp_pkg::ST_PCH:
          if (rx_valid)
          begin
            pc_hi_ff <= rx_data;
            state_ff <= dcp_pkg::ST_PCL;
          end
        dcp_pkg::ST_PCL:
          if (rx_valid)
            state_ff <= dcp_pkg::ST_IDLE;
        dcp_pkg::ST_WAH, dcp_pkg::ST_RAH:
          if (rx_valid)
          begin
            addr_ff[11:8] <= rx_data[3:0];
            state_ff      <= (state_ff == dcp_pkg::ST_WAH) ? dcp_pkg::ST_WAL
                                                           : dcp_pkg::ST_RAL;
          end
        dcp_pkg::ST_WAL, dcp_pkg::ST_RAL:
          if (rx_valid)
          begin
            addr_ff[7:0] <= rx_data;
            state_ff     <= (state_ff == dcp_pkg::ST_WAL) ? dcp_pkg::ST_WSZ
                                                          : dcp_pkg::ST_RSZ;
          end
        dcp_pkg::ST_WSZ:
          if (rx_valid)
          begin
            cnt_ff   <= size_cnt;
            state_ff <= dcp_pkg::ST_WDAT;
          end
        dcp_pkg::ST_WDAT:
          if (rx_valid)
          begin
            // Address steps after each byte, wrapping inside 4 KB
            addr_ff  <= addr_ff + 12'h001;
            cnt_ff   <= cnt_ff - 9'h001;
            state_ff <= (cnt_ff == 9'h001) ? dcp_pkg::ST_IDLE : dcp_pkg::ST_WDAT;
          end
        dcp_pkg::ST_RSZ:
          if (rx_valid)
          begin
            cnt_ff   <= size_cnt;
            state_ff <= dcp_pkg::ST_RREQ;
          end
        dcp_pkg::ST_RREQ:
          state_ff <= dcp_pkg::ST_RWAIT;
        dcp_pkg::ST_RWAIT:
          state_ff <= dcp_pkg::ST_RDATA;
        dcp_pkg::ST_RDATA:
        begin
          addr_ff      <= addr_ff + 12'h001;
          cnt_ff       <= cnt_ff - 9'h001;
          ret_state_ff <= (cnt_ff == 9'h001) ? dcp_pkg::ST_IDLE : dcp_pkg::ST_RREQ;
          state_ff     <= dcp_pkg::ST_TXWAIT;
        end
        dcp_pkg::ST_TXWAIT:
          // The load pulse must land before busy can be trusted
          if (!load_ff && !rp_if.busy)
            state_ff <= ret_state_ff;
        default:
          state_ff <= dcp_pkg::ST_IDLE;
      endcase
    end
  end

  // Debug control register; protection makes the halt bit sticky until reset
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      ctl_ff <= `DCP_CTL_RESET;
    else if (state_ff == dcp_pkg::ST_WCTL && rx_valid)
    begin
      ctl_ff <= rx_data;
      if (read_protect)
        ctl_ff[`DCP_HALT_BIT] <= ctl_ff[`DCP_HALT_BIT] | rx_data[`DCP_HALT_BIT];
    end
  end

  // Program counter load strobe, suppressed when access is closed
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pc_load_ff <= 1'b0;
      pc_val_ff  <= 16'h0000;
    end
    else
    begin
      pc_load_ff <= 1'b0;
      if (state_ff == dcp_pkg::ST_PCL && rx_valid && access_ok)
      begin
        pc_load_ff <= 1'b1;
        pc_val_ff  <= {pc_hi_ff, rx_data};
      end
    end
  end

  // Register file write strobe; addresses are applied with the data
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rf_wr_ff <= 1'b0;
      wdata_ff <= 8'h00;
    end
    else
    begin
      rf_wr_ff <= 1'b0;
      if (state_ff == dcp_pkg::ST_WDAT && rx_valid)
      begin
        wdata_ff <= rx_data;
        // Bytes are still counted when dropped, so framing stays aligned
        rf_wr_ff <= debug_on && (!read_protect || flash_hit);
      end
    end
  end

  // Register file read strobe; data is expected one cycle later
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      rf_rd_ff <= 1'b0;
    else
      rf_rd_ff <= (state_ff == dcp_pkg::ST_RREQ) && access_ok;
  end

  // Strobe address, latched with each strobe so the stepping counter never shows under it
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      rf_addr_ff <= 12'h000;
    else if ((state_ff == dcp_pkg::ST_WDAT && rx_valid) || state_ff == dcp_pkg::ST_RREQ)
      rf_addr_ff <= addr_ff;
  end

  // Reply byte selection for the sender
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      load_ff   <= 1'b0;
      two_ff    <= 1'b0;
      first_ff  <= 8'h00;
      second_ff <= 8'h00;
    end
    else
    begin
      load_ff <= 1'b0;
      if (state_ff == dcp_pkg::ST_IDLE && rx_valid && rx_data == `DCP_CMD_RD_CTL)
      begin
        load_ff  <= 1'b1;
        two_ff   <= 1'b0;
        first_ff <= ctl_ff;
      end
      else if (state_ff == dcp_pkg::ST_IDLE && rx_valid && rx_data == `DCP_CMD_RD_PC)
      begin
        load_ff   <= 1'b1;
        two_ff    <= 1'b1;
        first_ff  <= access_ok ? program_counter[15:8] : `DCP_BLOCKED_BYTE;
        second_ff <= access_ok ? program_counter[7:0] : `DCP_BLOCKED_BYTE;
      end
      else if (state_ff == dcp_pkg::ST_RDATA)
      begin
        load_ff  <= 1'b1;
        two_ff   <= 1'b0;
        first_ff <= access_ok ? rf_rdata : `DCP_BLOCKED_BYTE;
      end
    end
  end

  dcp_reply u_reply (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .rp       (rp_if.snk),
    .tx_ready (tx_ready),
    .tx_valid (tx_valid),
    .tx_data  (tx_data)
  );

endmodule : dcp_top

// ==== design/dcp_defines.svh ====
`ifndef DCP_DEFINES_SVH
`define DCP_DEFINES_SVH

// Command codes on the debug byte stream
`define DCP_CMD_WR_CTL      8'h04
`define DCP_CMD_RD_CTL      8'h05
`define DCP_CMD_WR_PC       8'h06
`define DCP_CMD_RD_PC       8'h07
`define DCP_CMD_WR_REG      8'h08
`define DCP_CMD_RD_REG      8'h09

// Field positions, reset values and the fill values for blocked reads
`define DCP_HALT_BIT        7
`define DCP_CTL_RESET       8'h00
`define DCP_BLOCKED_BYTE    8'hFF
`define DCP_BLOCKED_PC      16'hFFFF

// Register file address window of the flash control registers
`define DCP_FLASH_LO        12'hFF8
`define DCP_FLASH_HI        12'hFFB

// A size byte of zero stands for this many bytes
`define DCP_SIZE_ZERO_CNT   9'h100

`endif

// ==== design/dcp_pkg.sv ====
package dcp_pkg;

  // Command decoder states
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0000,
    ST_WCTL   = 4'b0001,
    ST_PCH    = 4'b0010,
    ST_PCL    = 4'b0011,
    ST_WAH    = 4'b0100,
    ST_WAL    = 4'b0101,
    ST_WSZ    = 4'b0110,
    ST_WDAT   = 4'b0111,
    ST_RAH    = 4'b1000,
    ST_RAL    = 4'b1001,
    ST_RSZ    = 4'b1010,
    ST_RREQ   = 4'b1011,
    ST_RWAIT  = 4'b1100,
    ST_RDATA  = 4'b1101,
    ST_TXWAIT = 4'b1110
  } dcp_state_type;

endpackage : dcp_pkg

// ==== design/dcp_reply_if.sv ====
`timescale 1ns/1ps
// Hand-off of one or two reply bytes from the decoder to the reply sender
interface dcp_reply_if;
  logic       load;
  logic       two;
  logic [7:0] first;
  logic [7:0] second;
  logic       busy;

  modport src (output load, output two, output first, output second, input busy);
  modport snk (input load, input two, input first, input second, output busy);
endinterface : dcp_reply_if

// ==== design/dcp_reply.sv ====
`timescale 1ns/1ps
// Sends up to two queued reply bytes with a valid/ready handshake
module dcp_reply (
  input  wire logic    sys_clk,
  input  wire logic    resetn,
  dcp_reply_if.snk     rp,
  input  wire logic    tx_ready,
  output logic         tx_valid,
  output logic [7:0]   tx_data
);

  logic [1:0] cnt_ff;
  logic [7:0] next_byte_ff;
  logic       valid_ff;
  logic [7:0] data_ff;

  assign rp.busy  = (cnt_ff != 2'h0);
  assign tx_valid = valid_ff;
  assign tx_data  = data_ff;

  // Byte queue; the decoder never loads while busy, so no overrun check
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_ff       <= 2'h0;
      next_byte_ff <= 8'h00;
      valid_ff     <= 1'b0;
      data_ff      <= 8'h00;
    end
    else if (rp.load)
    begin
      cnt_ff       <= rp.two ? 2'h2 : 2'h1;
      next_byte_ff <= rp.second;
      valid_ff     <= 1'b1;
      data_ff      <= rp.first;
    end
    else if (valid_ff && tx_ready)
    begin
      // Second byte follows the first back to back
      cnt_ff       <= cnt_ff - 2'h1;
      valid_ff     <= (cnt_ff == 2'h2);
      data_ff      <= next_byte_ff;
    end
  end

endmodule : dcp_reply

// ==== sim/dcp_host.sv ====
`timescale 1ns/1ps
// Debug host stand-in: sends command bytes, drains reply bytes
module dcp_host (
  input  wire logic       sys_clk,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            tx_ready,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data
);
  // Idle link at time zero
  initial
  begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b0;
  end

  // Command byte then operands, one per cycle; entered at a rising edge
  task automatic send(input logic [7:0] q[$]);
    foreach (q[i])
    begin
      rx_valid <= 1'b1;
      rx_data  <= q[i];
      @(posedge sys_clk);
    end
    rx_valid <= 1'b0;
    rx_data  <= ~rx_data; // Released byte lane must not repeat the last value
  endtask : send

  // Stalls first, then keeps ready up until n bytes have been taken
  task automatic recv(input int stall, input int n, output logic [15:0] w);
    w = 16'h0000;
    repeat (stall) @(posedge sys_clk);
    tx_ready <= 1'b1;
    repeat (n)
    begin
      repeat (30)
      begin
        @(posedge sys_clk);
        if (tx_valid === 1'b1)
          break;
      end
      // A byte that never came reads unknown, so the caller's compare fails
      w = {w[7:0], (tx_valid === 1'b1) ? tx_data : 8'hxx};
    end
    tx_ready <= 1'b0;
  endtask : recv
endmodule : dcp_host

// ==== sim/dcp_top_props.sv ====
`timescale 1ns/1ps
// Port-level checks of the debug command decoder
module dcp_top_props (
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        read_protect,
  input wire logic        tx_ready,
  input wire logic        tx_valid,
  input wire logic [7:0]  tx_data,
  input wire logic [7:0]  debug_control_reg,
  input wire logic        debug_halt_mode_bit,
  input wire logic        pc_load,
  input wire logic        rf_wr,
  input wire logic        rf_rd,
  input wire logic [11:0] rf_addr
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  chk_halt_sticky: assert property ($past(read_protect) && $past(debug_halt_mode_bit)
    |-> debug_halt_mode_bit) else $error("halt bit cleared under protect");
  chk_halt_mirror: assert property (debug_halt_mode_bit == debug_control_reg[7])
    else $error("halt bit differs from control bit 7");
  chk_pc_gate: assert property (pc_load |-> debug_halt_mode_bit && !read_protect)
    else $error("counter loaded while blocked");
  chk_pc_pulse: assert property (pc_load |=> !pc_load)
    else $error("counter load longer than one cycle");
  chk_wr_gate: assert property (rf_wr |-> debug_halt_mode_bit &&
    (!read_protect || rf_addr inside {[12'hFF8:12'hFFB]})) else $error("blocked write");
  chk_rd_gate: assert property (rf_rd |-> debug_halt_mode_bit && !read_protect)
    else $error("register read while blocked");
  chk_rd_reply: assert property (rf_rd |-> ##[1:6] tx_valid)
    else $error("no reply after register read");
  chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply byte dropped before ready");
endmodule : dcp_top_props

bind dcp_top dcp_top_props u_props (.sys_clk, .resetn, .read_protect, .tx_ready, .tx_valid,
  .tx_data, .debug_control_reg, .debug_halt_mode_bit, .pc_load, .rf_wr, .rf_rd, .rf_addr);

// ==== sim/dcp_top_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(a, e, m) begin n_tests++; if ((a) !== (e)) begin fail_count++; $display("mismatch %0t %s", $time, m); end end
module dcp_top_tb_top;
  logic        sys_clk, resetn, read_protect, rx_valid, tx_ready, tx_valid;
  logic        debug_halt_mode_bit, pc_load, rf_wr, rf_rd;
  logic [15:0] program_counter, pc_load_value, w;
  logic [7:0]  rf_rdata, rx_data, tx_data, debug_control_reg, rf_wdata, wdat;
  logic [11:0] rf_addr, waddr;
  logic [7:0]  q[$];
  int          fail_count, n_tests, nwr, npc;

  dcp_top DUT (.sys_clk, .resetn, .rx_valid, .rx_data, .read_protect, .program_counter,
    .rf_rdata, .tx_ready, .tx_valid, .tx_data, .debug_control_reg, .debug_halt_mode_bit,
    .pc_load, .pc_load_value, .rf_wr, .rf_rd, .rf_addr, .rf_wdata);
  dcp_host host (.sys_clk, .rx_valid, .rx_data, .tx_ready, .tx_valid, .tx_data);

  // 40 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Register file stand-in; unread data toggles so stale bytes never match
  always @(posedge sys_clk)
  begin
    rf_rdata <= (rf_rd === 1'b1) ? (rf_addr[7:0] ^ 8'h5A) : ~rf_rdata;
    if (rf_wr === 1'b1)
    begin
      nwr++;
      waddr = rf_addr;
      wdat = rf_wdata;
    end
    if (pc_load === 1'b1)
      npc++;
  end

  task automatic gap(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : gap

  // Reset also is the only way out of protected debug mode
  task automatic rst;
    resetn <= 1'b0;
    read_protect <= 1'b0;
    gap(12);
    resetn <= 1'b1;
    gap(1);
    `CHK(debug_control_reg, 8'h00, "control after reset")
  endtask : rst

  task automatic t_ctl;
    host.send({8'h01});
    gap(2);
    host.send({8'h04, 8'h81});
    gap(2);
    host.send({8'h05});
    host.recv(3, 1, w);
    gap(2);
    `CHK(w[7:0], 8'h81, "control read")
  endtask : t_ctl

  task automatic t_pc;
    host.send({8'h06, 8'h12, 8'h34});
    gap(3);
    `CHK({npc, pc_load_value}, {32'd1, 16'h1234}, "counter write")
    host.send({8'h07});
    host.recv(0, 2, w);
    gap(2);
    `CHK(w, 16'hA5C3, "counter read")
  endtask : t_pc

  // Two bytes, then 256 bytes by size zero wrapping the 12-bit address
  task automatic t_wr;
    host.send({8'h08, 8'h01, 8'h23, 8'h02, 8'hC4, 8'h3B});
    gap(3);
    `CHK({nwr, waddr, wdat}, {32'd2, 12'h124, 8'h3B}, "short write")
    q = {8'h08, 8'h0F, 8'hFF, 8'h00};
    for (int i = 0; i < 256; i++)
      q.push_back(i[7:0]);
    host.send(q);
    gap(3);
    `CHK({nwr, waddr, wdat}, {32'd258, 12'h0FE, 8'hFF}, "size zero")
    host.send({8'h09, 8'h00, 8'h40, 8'h03});
    host.recv(1, 3, w);
    gap(2);
    `CHK(w, {8'h41 ^ 8'h5A, 8'h42 ^ 8'h5A}, "register read")
  endtask : t_wr

  task automatic t_prot;
    read_protect <= 1'b1;
    gap(2);
    host.send({8'h04, 8'h00});
    gap(2);
    `CHK(debug_halt_mode_bit, 1'b1, "halt cleared")
    host.send({8'h06, 8'hAB, 8'hCD});
    gap(3);
    `CHK(npc, 1, "protected counter write")
    host.send({8'h07});
    host.recv(0, 2, w);
    gap(2);
    `CHK(w, 16'hFFFF, "protected counter read")
    host.send({8'h08, 8'h0F, 8'hF7, 8'h02, 8'h11, 8'h22});
    gap(3);
    `CHK({nwr, waddr, wdat}, {32'd259, 12'hFF8, 8'h22}, "flash window")
    host.send({8'h09, 8'h00, 8'h40, 8'h01});
    host.recv(0, 1, w);
    gap(2);
    `CHK(w[7:0], 8'hFF, "protected read")
  endtask : t_prot

  task automatic t_off;
    host.send({8'h08, 8'h01, 8'h00, 8'h01, 8'h55});
    gap(3);
    `CHK(nwr, 259, "write outside debug")
    host.send({8'h06, 8'h01, 8'h02});
    gap(3);
    `CHK(npc, 1, "counter write outside debug")
    host.send({8'h07});
    host.recv(0, 2, w);
    gap(2);
    `CHK(w, 16'hFFFF, "counter read outside debug")
    host.send({8'h09, 8'h00, 8'h40, 8'h01});
    host.recv(0, 1, w);
    gap(2);
    `CHK(w[7:0], 8'hFF, "register read outside debug")
  endtask : t_off

  task finish_test;
    if (fail_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  // Main sequence
  initial
  begin
    program_counter = 16'hA5C3;
    rst();
    t_ctl();
    t_pc();
    t_wr();
    t_prot();
    rst();
    t_off();
    finish_test();
  end

  // Watchdog, far beyond the few hundred cycles the run needs
  initial
  begin
    gap(20000);
    fail_count++;
    finish_test();
  end
endmodule : dcp_top_tb_top
